// ==== rtl/scfg_regs.sv ====
// Serial configuration bank: wiring mode, page selects and top-page controls.
// Assumes the serial pins come straight from package pins (unsynchronised).
`timescale 1ns/10ps

// What this block does
// - Bit 0 at 010h picks four-wire (clear) or three-wire shared data pin.
// - Converter page byte all ones selects converter page; all zeros is normal.
// - Top-page select bit 2 routes later accesses to top-level page registers.
// - Reference-pulse buffer powerdown bit blocks every further reference pulse.
// - Channel-B powerdown bit powers channel B down; clearing restores it.
// - Channel-B powerdown acts only while the gate bit at 039h is set.
// - Bit 0 at 020h enables full-chip powerdown; clear is normal.
// - Bit 5 at 032h drives the bias network through high impedance.
// - Bit 0 at 039h switches the sync input termination off.
// - Every field of 010h, 012h, 020h, 032h, 039h resets to zero.
module scfg_regs (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic spi_sclk,
  input  wire logic spi_sen_n,
  input  wire logic serial_data_in_pin,
  input  wire logic refpulse_pin,
  output logic      spi_sdout,
  output logic      serial_data_in_pin_drv,
  output logic      serial_data_in_pin_oe_n,
  output logic      three_wire_mode,
  output logic      converter_page_active,
  output logic      top_page_active,
  output logic      refpulse_capture,
  output logic      chan_b_powerdown,
  output logic      full_chip_powerdown,
  output logic      common_mode_high_impedance,
  output logic      sync_input_termination_off
);

  scfg_frame_if f ();

  logic       wire_mode_ff;
  logic [7:0] conv_page_ff;
  logic       top_page_ff;
  logic       refpulse_buffer_powerdown_ff;
  logic       chan_b_powerdown_req_ff;
  logic       full_chip_powerdown_ff;
  logic       common_mode_high_impedance_ff;
  logic       chan_b_powerdown_gate_ff;
  logic       sync_input_termination_off_ff;
  logic       conv_active_ff;
  logic       chb_out_ff;
  logic       ref_s1_ff, ref_s2_ff, ref_s3_ff;
  logic       ref_cap_ff;
  logic       sdout_w, sdio_drv_w, sdio_oe_n_w;

  // ==========================================================================
  // Serial frame shifter
  scfg_spi_shift u_shift (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .ce           (ce),
    .sclk_pin     (spi_sclk),
    .sen_n_pin    (spi_sen_n),
    .data_pin     (serial_data_in_pin),
    .f            (f.link),
    .sdout_ff     (sdout_w),
    .sdio_drv_ff  (sdio_drv_w),
    .sdio_oe_n_ff (sdio_oe_n_w)
  );

  // ==========================================================================
  // Address decode
  // The top-page group is invisible unless its select is set, so a stray
  // write during converter-page work cannot power anything down.
  wire hit_wire = (f.addr == scfg_pkg::OFS_WIRE);
  wire hit_conv = (f.addr == scfg_pkg::OFS_CONV);
  wire hit_top  = (f.addr == scfg_pkg::OFS_TOP);
  wire hit_pd   = top_page_ff && (f.addr == scfg_pkg::OFS_PD);
  wire hit_cm   = top_page_ff && (f.addr == scfg_pkg::OFS_CM);
  wire hit_gate = top_page_ff && (f.addr == scfg_pkg::OFS_GATE);

  wire wr_wire  = f.wr_stb & hit_wire;
  wire wr_conv  = f.wr_stb & hit_conv;
  wire wr_top   = f.wr_stb & hit_top;
  wire wr_pd    = f.wr_stb & hit_pd;
  wire wr_cm    = f.wr_stb & hit_cm;
  wire wr_gate  = f.wr_stb & hit_gate;

  // Fixed-one and reserved bits of 039h are not stored: binds the host.
  wire [7:0] rd_wire = {7'h00, wire_mode_ff};
  wire [7:0] rd_top  = {5'h00, top_page_ff, 2'h0};
  wire [7:0] rd_pd   = {3'h0, refpulse_buffer_powerdown_ff, 2'h0,
                        chan_b_powerdown_req_ff, full_chip_powerdown_ff};
  wire [7:0] rd_cm   = {2'h0, common_mode_high_impedance_ff, 5'h00};
  wire [7:0] rd_gate = {6'h00, chan_b_powerdown_gate_ff,
                        sync_input_termination_off_ff};

  assign f.rdata = hit_wire ? rd_wire :
                   hit_conv ? conv_page_ff :
                   hit_top  ? rd_top  :
                   hit_pd   ? rd_pd   :
                   hit_cm   ? rd_cm   :
                   hit_gate ? rd_gate : 8'h00;
  assign f.three_wire = wire_mode_ff;

  wire nxt_chb_out  = chan_b_powerdown_req_ff & chan_b_powerdown_gate_ff;
  wire ref_rise     = ref_s2_ff & ~ref_s3_ff;
  wire nxt_ref_cap  = ref_rise & ~refpulse_buffer_powerdown_ff;
  wire nxt_conv_act = (conv_page_ff == scfg_pkg::CONV_PAGE_ON);

  // ==========================================================================
  // Register storage
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wire_mode_ff                  <= scfg_pkg::RST_BIT;
      conv_page_ff                  <= scfg_pkg::RST_BYTE;
      top_page_ff                   <= scfg_pkg::RST_BIT;
      refpulse_buffer_powerdown_ff  <= scfg_pkg::RST_BIT;
      chan_b_powerdown_req_ff       <= scfg_pkg::RST_BIT;
      full_chip_powerdown_ff        <= scfg_pkg::RST_BIT;
      common_mode_high_impedance_ff <= scfg_pkg::RST_BIT;
      chan_b_powerdown_gate_ff      <= scfg_pkg::RST_BIT;
      sync_input_termination_off_ff <= scfg_pkg::RST_BIT;
    end else if (ce) begin
      if (wr_wire) begin
        wire_mode_ff <= f.wdata[scfg_pkg::BIT_WIRE];
      end
      if (wr_conv) begin
        conv_page_ff <= f.wdata;
      end
      if (wr_top) begin
        top_page_ff <= f.wdata[scfg_pkg::BIT_TOP];
      end
      if (wr_pd) begin
        refpulse_buffer_powerdown_ff <= f.wdata[scfg_pkg::BIT_PD_REF];
        chan_b_powerdown_req_ff      <= f.wdata[scfg_pkg::BIT_PD_CHB];
        full_chip_powerdown_ff       <= f.wdata[scfg_pkg::BIT_PD_ALL];
      end
      if (wr_cm) begin
        common_mode_high_impedance_ff <= f.wdata[scfg_pkg::BIT_CM_HIZ];
      end
      if (wr_gate) begin
        chan_b_powerdown_gate_ff      <= f.wdata[scfg_pkg::BIT_CHB_GATE];
        sync_input_termination_off_ff <= f.wdata[scfg_pkg::BIT_TERM_OFF];
      end
    end
  end

  // ==========================================================================
  // Output stage and reference-pulse capture
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      conv_active_ff <= 1'b0;
      chb_out_ff     <= 1'b0;
      ref_s1_ff      <= 1'b0;
      ref_s2_ff      <= 1'b0;
      ref_s3_ff      <= 1'b0;
      ref_cap_ff     <= 1'b0;
    end else if (ce) begin
      conv_active_ff <= nxt_conv_act;
      chb_out_ff     <= nxt_chb_out;
      ref_s1_ff      <= refpulse_pin;
      ref_s2_ff      <= ref_s1_ff;
      ref_s3_ff      <= ref_s2_ff;
      ref_cap_ff     <= nxt_ref_cap;
    end
  end

  assign spi_sdout                  = sdout_w;
  assign serial_data_in_pin_drv     = sdio_drv_w;
  assign serial_data_in_pin_oe_n    = sdio_oe_n_w;
  assign three_wire_mode            = wire_mode_ff;
  assign converter_page_active      = conv_active_ff;
  assign top_page_active            = top_page_ff;
  assign refpulse_capture           = ref_cap_ff;
  assign chan_b_powerdown           = chb_out_ff;
  assign full_chip_powerdown        = full_chip_powerdown_ff;
  assign common_mode_high_impedance = common_mode_high_impedance_ff;
  assign sync_input_termination_off = sync_input_termination_off_ff;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_wire_write;
    ce && f.wr_stb && f.addr == scfg_pkg::OFS_WIRE;
  endsequence
  sequence s_pd_write_hidden;
    ce && f.wr_stb && f.addr == scfg_pkg::OFS_PD && !top_page_ff;
  endsequence

  property p_wire_mode;
    s_wire_write |=> three_wire_mode == $past(f.wdata[0]);
  endproperty
  a_wire_mode: assert property (p_wire_mode)
    else $error("wiring mode did not follow the write");

  property p_conv_page;
    ce |=> converter_page_active == ($past(conv_page_ff) == 8'hff);
  endproperty
  a_conv_page: assert property (p_conv_page)
    else $error("converter page decode wrong");

  property p_hidden_write;
    s_pd_write_hidden |=> $stable(full_chip_powerdown)
                          && $stable(chan_b_powerdown_req_ff)
                          && $stable(refpulse_buffer_powerdown_ff);
  endproperty
  a_hidden_write: assert property (p_hidden_write)
    else $error("power-down changed with top page deselected");

  property p_top_route;
    ce && f.wr_stb && f.addr == scfg_pkg::OFS_PD && top_page_ff
      |=> full_chip_powerdown == $past(f.wdata[0]);
  endproperty
  a_top_route: assert property (p_top_route)
    else $error("top-page write not routed");

  property p_ref_block;
    refpulse_buffer_powerdown_ff && $past(refpulse_buffer_powerdown_ff)
      |-> !refpulse_capture;
  endproperty
  a_ref_block: assert property (p_ref_block)
    else $error("reference pulse passed while powered down");

  property p_chb_gate;
    ce ##1 ce |-> ##1 chan_b_powerdown
      == $past(chan_b_powerdown_req_ff & chan_b_powerdown_gate_ff);
  endproperty
  a_chb_gate: assert property (p_chb_gate)
    else $error("channel B power-down not gated");

  property p_chb_on;
    ce && chan_b_powerdown_req_ff && chan_b_powerdown_gate_ff
      |=> chan_b_powerdown;
  endproperty
  a_chb_on: assert property (p_chb_on)
    else $error("channel B did not power down");

  property p_cm_gate;
    ce && f.wr_stb && f.addr == scfg_pkg::OFS_CM && top_page_ff
      |=> common_mode_high_impedance == $past(f.wdata[5]);
  endproperty
  a_cm_gate: assert property (p_cm_gate)
    else $error("common-mode impedance bit not stored");

  property p_term;
    ce && f.wr_stb && f.addr == scfg_pkg::OFS_GATE && top_page_ff
      |=> sync_input_termination_off == $past(f.wdata[0]);
  endproperty
  a_term: assert property (p_term)
    else $error("termination bit not stored");

  property p_read_zero;
    f.addr == scfg_pkg::OFS_GATE |-> f.rdata[7:2] == 6'h00;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("reserved bits read nonzero");

endmodule : scfg_regs

// ==== rtl/scfg_pkg.sv ====
// Constants shared by the serial configuration bank and its frame shifter.
// Assumes a byte-wide register map reached by 24-bit serial frames.
package scfg_pkg;

  // ==========================================================================
  // Frame layout
  localparam int unsigned ADDR_W     = 15;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FRAME_W    = 24;
  localparam logic [4:0]  CNT_HDR    = 5'h10;
  localparam logic [4:0]  CNT_FRAME  = 5'h18;
  localparam int unsigned RW_POS     = 15;

  // ==========================================================================
  // Register offsets
  localparam logic [14:0] OFS_WIRE   = 15'h0010;
  localparam logic [14:0] OFS_CONV   = 15'h0011;
  localparam logic [14:0] OFS_TOP    = 15'h0012;
  localparam logic [14:0] OFS_PD     = 15'h0020;
  localparam logic [14:0] OFS_CM     = 15'h0032;
  localparam logic [14:0] OFS_GATE   = 15'h0039;

  // ==========================================================================
  // Field positions
  localparam int unsigned BIT_WIRE     = 0;
  localparam int unsigned BIT_TOP      = 2;
  localparam int unsigned BIT_PD_REF   = 4;
  localparam int unsigned BIT_PD_CHB   = 1;
  localparam int unsigned BIT_PD_ALL   = 0;
  localparam int unsigned BIT_CM_HIZ   = 5;
  localparam int unsigned BIT_CHB_GATE = 1;
  localparam int unsigned BIT_TERM_OFF = 0;

  // ==========================================================================
  // Values after reset and decodes
  localparam logic       RST_BIT      = 1'b0;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] CONV_PAGE_ON = 8'hff;

  typedef enum logic [1:0] {
    SCFG_PH_HDR  = 2'b00,
    SCFG_PH_WR   = 2'b01,
    SCFG_PH_RD   = 2'b10,
    SCFG_PH_DONE = 2'b11
  } scfg_phase_t;

endpackage : scfg_pkg

// ==== rtl/scfg_frame_if.sv ====
// Carries decoded serial frames between the shifter and the register bank.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface scfg_frame_if;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic [7:0]  rdata;
  logic        three_wire;

  modport link (output addr, output wdata, output wr_stb,
                input rdata, input three_wire);
  modport bank (input addr, input wdata, input wr_stb,
                output rdata, output three_wire);
endinterface : scfg_frame_if

// ==== rtl/scfg_spi_shift.sv ====
// Serial frame shifter: oversamples the serial pins on the system clock.
// Assumes the serial clock half period spans at least three system clocks.
`timescale 1ns/10ps
module scfg_spi_shift (
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  input  wire logic   ce,
  input  wire logic   sclk_pin,
  input  wire logic   sen_n_pin,
  input  wire logic   data_pin,
  scfg_frame_if.link  f,
  output logic        sdout_ff,
  output logic        sdio_drv_ff,
  output logic        sdio_oe_n_ff
);

  logic                 sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic                 sen_s1_ff, sen_s2_ff;
  logic                 din_s1_ff, din_s2_ff;
  logic [4:0]           cnt_ff;
  logic [23:0]          sh_ff;
  logic [7:0]           out_ff;
  logic                 load_ff;
  scfg_pkg::scfg_phase_t ph_ff;

  wire        rise   = sclk_s2_ff & ~sclk_s3_ff;
  wire        fall   = ~sclk_s2_ff & sclk_s3_ff;
  wire        active = ~sen_s2_ff;
  wire [23:0] nxt_sh = {sh_ff[22:0], din_s2_ff};
  wire        hdr_end = (cnt_ff == scfg_pkg::CNT_HDR - 5'h01);
  wire        frm_end = (cnt_ff == scfg_pkg::CNT_FRAME - 5'h01);

  // ==========================================================================
  // Frame sequencing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_s1_ff   <= 1'b0;
      sclk_s2_ff   <= 1'b0;
      sclk_s3_ff   <= 1'b0;
      sen_s1_ff    <= 1'b1;
      sen_s2_ff    <= 1'b1;
      din_s1_ff    <= 1'b0;
      din_s2_ff    <= 1'b0;
      cnt_ff       <= 5'h00;
      sh_ff        <= 24'h000000;
      out_ff       <= 8'h00;
      load_ff      <= 1'b0;
      ph_ff        <= scfg_pkg::SCFG_PH_HDR;
      f.addr       <= 15'h0000;
      f.wdata      <= 8'h00;
      f.wr_stb     <= 1'b0;
      sdout_ff     <= 1'b0;
      sdio_drv_ff  <= 1'b0;
      sdio_oe_n_ff <= 1'b1;
    end else if (ce) begin
      sclk_s1_ff <= sclk_pin;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      sen_s1_ff  <= sen_n_pin;
      sen_s2_ff  <= sen_s1_ff;
      din_s1_ff  <= data_pin;
      din_s2_ff  <= din_s1_ff;
      f.wr_stb   <= 1'b0;
      load_ff    <= 1'b0;
      if (!active) begin
        cnt_ff       <= 5'h00;
        ph_ff        <= scfg_pkg::SCFG_PH_HDR;
        sdio_oe_n_ff <= 1'b1;
      end else begin
        if (rise && ph_ff != scfg_pkg::SCFG_PH_DONE) begin
          sh_ff  <= nxt_sh;
          cnt_ff <= cnt_ff + 5'h01;
          if (hdr_end) begin
            f.addr <= nxt_sh[14:0];
            if (nxt_sh[scfg_pkg::RW_POS]) begin
              ph_ff   <= scfg_pkg::SCFG_PH_RD;
              load_ff <= 1'b1;
            end else begin
              ph_ff <= scfg_pkg::SCFG_PH_WR;
            end
          end
          if (frm_end) begin
            ph_ff <= scfg_pkg::SCFG_PH_DONE;
            if (ph_ff == scfg_pkg::SCFG_PH_WR) begin
              f.wdata  <= nxt_sh[7:0];
              f.wr_stb <= 1'b1;
            end
          end
        end
        // Read data leaves on falling edges so the host samples it on rising.
        if (fall && ph_ff == scfg_pkg::SCFG_PH_RD) begin
          sdout_ff     <= out_ff[7] & ~f.three_wire;
          sdio_drv_ff  <= out_ff[7];
          sdio_oe_n_ff <= ~f.three_wire;
          out_ff       <= {out_ff[6:0], 1'b0};
        end
        if (load_ff) begin
          out_ff <= f.rdata;
        end
      end
    end
  end

  // ==========================================================================
  // Assertions
  // The shared pin may only be driven in three-wire mode; in four-wire mode
  // the host owns it for the whole frame.
  property p_pin_release;
    @(posedge sys_clk) disable iff (!nrst)
      !f.three_wire |-> sdio_oe_n_ff;
  endproperty
  a_pin_release: assert property (p_pin_release)
    else $error("shared data pin driven in four-wire mode");

  property p_pin_drive;
    @(posedge sys_clk) disable iff (!nrst)
      ce && active && fall && ph_ff == scfg_pkg::SCFG_PH_RD && f.three_wire
        |=> !sdio_oe_n_ff;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("shared data pin not driven during three-wire read");

endmodule : scfg_spi_shift

// ==== tb/scfg_host_model.sv ====
// Serial host model: frames one byte access at a time onto the pins.
// Assumes the bench resolves the shared data pin from both drivers.
`timescale 1ns/10ps
module scfg_host_model (
  input  wire logic sys_clk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      sen_n,
  output logic      sdi,
  output logic      sdi_en
);
  // ========================================
  // Frame engine
  initial begin
    sclk   = 1'b0;
    sen_n  = 1'b1;
    sdi    = 1'b0;
    sdi_en = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step

  // Five cycles a phase keeps the shifter's three-cycle minimum with margin.
  task automatic xfer(input logic [23:0] f, input logic tw,
                      output logic [7:0] rd);
    rd = 8'h00;
    step(1);
    sen_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sclk   = 1'b0;
      sdi    = f[i];
      sdi_en = !(tw && f[23] && i < 8);
      step(5);
      if (i < 8) rd[i] = sdo;
      sclk = 1'b1;
      step(5);
    end
    sclk = 1'b0;
    step(5);
    sen_n = 1'b1;
    step(10);
  endtask : xfer
endmodule : scfg_host_model

// ==== tb/tb_scfg_regs.sv ====
// Self-checking bench for the serial configuration bank.
// Assumes the host model on the pins and an integer register model here.
`timescale 1ns/10ps
module tb_scfg_regs;
  logic       sys_clk;
  logic       nrst;
  logic       ce;
  logic       refpulse_pin;
  logic       sclk;
  logic       sen_n;
  logic       sdi;
  logic       sdi_en;
  logic       junk = 1'b0;
  logic       spi_sdout;
  logic       drv;
  logic       oe_n;
  logic       tw_o;
  logic       conv_o;
  logic       top_o;
  logic       cap_o;
  logic       chb_o;
  logic       pd_o;
  logic       cm_o;
  logic       term_o;
  wire        pin;
  wire        host_sdo;
  int         m_wire;
  int         m_conv;
  int         m_top;
  int         m_pd;
  int         m_cm;
  int         m_gate;
  int         n_errors = 0;
  int         check_count = 0;
  int         cyc = 0;
  int         v;
  logic [7:0] rbuf;
  int         ofs[7] = '{8'h10, 8'h11, 8'h12, 8'h20, 8'h32, 8'h39, 8'h13};

  // An undriven shared pin toggles so a stale level never passes as data.
  assign pin      = !oe_n ? drv : (sdi_en ? sdi : junk);
  assign host_sdo = m_wire[0] ? pin : spi_sdout;

  scfg_regs scfg_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .spi_sclk(sclk), .spi_sen_n(sen_n), .serial_data_in_pin(pin),
    .refpulse_pin(refpulse_pin), .spi_sdout(spi_sdout),
    .serial_data_in_pin_drv(drv), .serial_data_in_pin_oe_n(oe_n),
    .three_wire_mode(tw_o), .converter_page_active(conv_o),
    .top_page_active(top_o), .refpulse_capture(cap_o),
    .chan_b_powerdown(chb_o), .full_chip_powerdown(pd_o),
    .common_mode_high_impedance(cm_o),
    .sync_input_termination_off(term_o));

  scfg_host_model scfg_host_model_inst (.sys_clk(sys_clk),
    .sdo(host_sdo), .sclk(sclk), .sen_n(sen_n), .sdi(sdi),
    .sdi_en(sdi_en));

  // ========================================
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // The run needs about 30000 cycles; twice that means a hang.
  always @(posedge sys_clk) begin
    junk <= ~junk;
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end

  // ========================================
  // Register model
  task automatic mdl_wr(input int a, input int d);
    case (a)
      8'h10: m_wire = d & 8'h01;
      8'h11: m_conv = d & 8'hff;
      8'h12: m_top = d & 8'h04;
      8'h20: if (m_top != 0) m_pd = d & 8'h13;
      8'h32: if (m_top != 0) m_cm = d & 8'h20;
      8'h39: if (m_top != 0) m_gate = d & 8'h03;
      default: ;
    endcase
  endtask : mdl_wr

  function automatic int mdl_rd(input int a);
    case (a)
      8'h10: return m_wire;
      8'h11: return m_conv;
      8'h12: return m_top;
      8'h20: return (m_top != 0) ? m_pd : 0;
      8'h32: return (m_top != 0) ? m_cm : 0;
      8'h39: return (m_top != 0) ? m_gate : 0;
      default: return 0;
    endcase
  endfunction : mdl_rd

  // ========================================
  // Checks and accesses
  task automatic chk1(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic check_outs;
    chk1("three_wire", m_wire[0], tw_o);
    chk1("pin_oe_n", 1'b1, oe_n);
    chk1("conv_page", m_conv == 8'hff, conv_o);
    chk1("top_page", m_top[2], top_o);
    chk1("chan_b_pd", m_pd[1] & m_gate[1], chb_o);
    chk1("chip_pd", m_pd[0], pd_o);
    chk1("cm_hiz", m_cm[5], cm_o);
    chk1("term_off", m_gate[0], term_o);
  endtask : check_outs

  task automatic wr(input int a, input int d);
    logic [7:0] r;
    scfg_host_model_inst.xfer({1'b0, 15'(a), 8'(d)}, m_wire[0], r);
    mdl_wr(a, d);
    check_outs();
  endtask : wr

  task automatic rd_chk(input int a);
    logic [7:0] r;
    scfg_host_model_inst.xfer({1'b1, 15'(a), 8'h00}, m_wire[0], r);
    chk8("rdata", 8'(mdl_rd(a)), r);
    chk1("pin_oe_n", 1'b1, oe_n);
  endtask : rd_chk

  task automatic pulse_chk;
    int n;
    n = 0;
    refpulse_pin = 1'b1;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      if (cap_o === 1'b1) n++;
    end
    refpulse_pin = 1'b0;
    scfg_host_model_inst.step(4);
    chk8("ref_pulses", m_pd[4] ? 8'h00 : 8'h01, 8'(n));
  endtask : pulse_chk

  task automatic do_reset(input int n);
    nrst   = 1'b0;
    m_wire = 0;
    m_conv = 0;
    m_top  = 0;
    m_pd   = 0;
    m_cm   = 0;
    m_gate = 0;
    scfg_host_model_inst.step(n);
    nrst = 1'b1;
    scfg_host_model_inst.step(2);
    check_outs();
    foreach (ofs[i]) rd_chk(ofs[i]);
  endtask : do_reset

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // ========================================
  // Main sequence
  initial begin
    v            = $urandom(50236);
    nrst         = 1'b0;
    ce           = 1'b1;
    refpulse_pin = 1'b0;
    do_reset(12);
    // A frame sent while the clock enable is low must leave no trace.
    ce = 1'b0;
    scfg_host_model_inst.xfer({1'b0, 15'h0010, 8'h01}, 1'b0, rbuf);
    ce = 1'b1;
    check_outs();
    rd_chk(8'h10);
    wr(8'h20, 8'h13);
    rd_chk(8'h20);
    wr(8'h12, 8'h04);
    pulse_chk();
    wr(8'h20, 8'h13);
    pulse_chk();
    wr(8'h39, 8'h53);
    wr(8'h32, 8'h20);
    wr(8'h20, 8'h10);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(8'h20, v & 8'h13);
      wr(8'h39, ((v >> 8) & 8'h03) | 8'h50);
      wr(8'h32, (v >> 16) & 8'h20);
      foreach (ofs[j]) rd_chk(ofs[j]);
      pulse_chk();
    end
    wr(8'h12, 8'h00);
    wr(8'h11, 8'h5a);
    wr(8'h11, 8'hff);
    wr(8'h39, 8'h50);
    rd_chk(8'h11);
    rd_chk(8'h39);
    wr(8'h11, 8'h00);
    wr(8'h10, 8'h01);
    wr(8'h12, 8'h04);
    foreach (ofs[j]) rd_chk(ofs[j]);
    do_reset(3);
    wr(8'h10, 8'h01);
    wr(8'h10, 8'h00);
    rd_chk(8'h10);
    finish_test();
  end
endmodule : tb_scfg_regs
